// File: shared/mie_pkg.sv
`default_nettype none
package mie_pkg;

  // Data path and program space widths.
  localparam int DATA_W = 8;
  localparam int PC_W = 11;
  localparam int INSTR_W = 16;
  localparam int DMEM_AW = 8;
  localparam int STACK_DEPTH = 8;

  // Instruction field positions.
  localparam int OPC_LSB = 11;
  localparam int BIT_LSB = 8;

  // Program counter values.
  localparam logic [PC_W-1:0] PC_RESET = 11'h000;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 11'h004;

  // Watchdog: prescaler cycles per tick, timer width.
  localparam int WDT_PRESCALE = 256;
  localparam int WDT_W = 8;

  // Decimal adjust constants.
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [3:0] BCD_NIBBLE_ADJ = 4'h6;

  // Avalon register map, byte addresses.
  localparam int AVL_AW = 11;
  localparam logic [AVL_AW-1:0] REG_CTRL = 11'h000;
  localparam logic [AVL_AW-1:0] REG_STATUS = 11'h004;
  localparam logic [AVL_AW-1:0] REG_WORK = 11'h008;
  localparam logic [AVL_AW-1:0] REG_PC = 11'h00C;
  localparam logic [AVL_AW-1:0] REG_WDT = 11'h010;
  localparam int DMEM_WIN_BIT = 10;

  // Control register bits.
  localparam int CTRL_WAKE = 0;
  localparam int CTRL_RESTART = 1;

  // Status register bits.
  localparam int ST_NULL = 0;
  localparam int ST_CARRY = 1;
  localparam int ST_NIBBLE = 2;
  localparam int ST_WRAP = 3;
  localparam int ST_SOVF = 4;
  localparam int ST_WDEXP = 5;
  localparam int ST_SLEEP = 6;
  localparam int ST_GATE = 7;
  localparam int ST_HALTED = 8;

  // Opcodes in instruction bits 15:11, encoded 0 to 31 in this order.
  typedef enum logic [4:0] {
    OP_NOP, OP_ADC, OP_ADD_WITH_CARRY_TO_MEMORY, OP_ADD, OP_ADDI, OP_SUM_TO_MEMORY, OP_AND, OP_ANDI,
    OP_CONJUNCTION_TO_MEMORY, OP_OR, OP_ORI, OP_ORM, OP_CALL, OP_CLR, OP_CLRB, OP_CLRWDT,
    OP_CPL, OP_INVERT_TO_WORK, OP_DAA, OP_DEC, OP_STEP_DOWN_TO_WORK, OP_INC, OP_STEP_UP_TO_WORK, OP_HALT,
    OP_JMP, OP_MOVAM, OP_MOVAI, OP_MOVMA, OP_RET, OP_RETA, OP_LEAVE_INTERRUPT_HANDLER, OP_RL
  } mie_op_t;

  typedef enum logic [1:0] {
    ST_RUN, ST_DUMMY, ST_SLEEP_ST
  } mie_state_t;

endpackage
`default_nettype wire

// File: hdl/mie_stack.sv
`timescale 1ns/1ps
`default_nettype none
module mie_stack #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 11
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Stack control.
  input wire logic clear_in,
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic [WIDTH-1:0] push_data_in,
  // Top of stack.
  output logic [WIDTH-1:0] top_out
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] slots [DEPTH];
  logic [PW-1:0] ptr;
  wire [PW-1:0] ptr_dec = ptr - 1'b1;
  wire [PW-1:0] ptr_inc = ptr + 1'b1;

  assign top_out = slots[ptr_dec];

  // The pointer wraps, so a push past the depth overwrites the oldest entry.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || clear_in) begin
      ptr <= '0;
    end else if (push_in) begin
      ptr <= ptr_inc;
    end else if (pop_in) begin
      ptr <= ptr_dec;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push_in) begin
      slots[ptr] <= push_data_in;
    end
  end

endmodule
`default_nettype wire

// File: hdl/mie_core.sv
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mie_core #(
  parameter int STACK_DEPTH = mie_pkg::STACK_DEPTH,
  parameter int WDT_PRESCALE = mie_pkg::WDT_PRESCALE
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Avalon-MM slave.
  input wire logic [mie_pkg::AVL_AW-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Program memory fetch port.
  output logic [mie_pkg::PC_W-1:0] prog_addr_out,
  input wire logic [mie_pkg::INSTR_W-1:0] prog_data_in,
  // Interrupt request pin and clock gate.
  input wire logic irq_in,
  output logic sys_clk_en_out
);

  localparam int PRE_W = $clog2(WDT_PRESCALE);
  localparam int DMEM_DEPTH = 1 << mie_pkg::DMEM_AW;

  mie_pkg::mie_state_t state;
  logic [mie_pkg::PC_W-1:0] pc;
  logic [7:0] work_register;
  logic [7:0] dmem [DMEM_DEPTH];
  logic result_null_flag;
  logic borrow_out_bit;
  logic nibble_carry_flag;
  logic signed_wrap_flag;
  logic signed_ovf_flag;
  logic watchdog_expired_flag;
  logic sleep_entered_flag;
  logic global_irq_gate;
  logic irq_meta;
  logic irq_sync;
  logic [PRE_W-1:0] wdt_pre;
  logic [mie_pkg::WDT_W-1:0] watchdog_timer;
  logic ack_q;
  logic [mie_pkg::PC_W-1:0] stack_top;
  logic [7:0] res;
  logic to_acc;
  logic to_mem;
  logic set_arith;
  logic set_z;
  logic set_daa;

  // Instruction fields.
  wire mie_pkg::mie_op_t op = mie_pkg::mie_op_t'(prog_data_in[mie_pkg::INSTR_W-1:mie_pkg::OPC_LSB]);
  wire [7:0] maddr = prog_data_in[7:0];
  wire [7:0] lit = prog_data_in[7:0];
  wire [2:0] bidx = prog_data_in[mie_pkg::BIT_LSB+2:mie_pkg::BIT_LSB];
  wire [mie_pkg::PC_W-1:0] target = prog_data_in[mie_pkg::PC_W-1:0];
  wire [7:0] mval = dmem[maddr];
  wire [mie_pkg::PC_W-1:0] pc_inc = pc + 1'b1;

  // Bus decode.
  wire bus_req = avs_read_in | avs_write_in;
  wire bus_dmem = avs_address_in[mie_pkg::DMEM_WIN_BIT];
  wire [7:0] bus_idx = avs_address_in[9:2];
  wire hit_ctrl = avs_address_in == mie_pkg::REG_CTRL;
  wire hit_status = avs_address_in == mie_pkg::REG_STATUS;
  wire hit_work = avs_address_in == mie_pkg::REG_WORK;
  wire hit_pc = avs_address_in == mie_pkg::REG_PC;
  wire hit_wdt = avs_address_in == mie_pkg::REG_WDT;
  wire bus_wr_lo = avs_write_in & avs_byteenable_in[0] & ~ack_q;
  wire bus_restart = bus_wr_lo & hit_ctrl & avs_writedata_in[mie_pkg::CTRL_RESTART];
  wire bus_wake = bus_wr_lo & hit_ctrl & avs_writedata_in[mie_pkg::CTRL_WAKE];

  // Execution qualifiers.
  wire running = state == mie_pkg::ST_RUN;
  wire irq_take = running & irq_sync & global_irq_gate & ~bus_restart;
  wire exec = running & ~irq_take & ~bus_restart;
  wire is_branch = (op == mie_pkg::OP_CALL) | (op == mie_pkg::OP_JMP);
  wire is_return = (op == mie_pkg::OP_RET) | (op == mie_pkg::OP_RETA) | (op == mie_pkg::OP_LEAVE_INTERRUPT_HANDLER);
  wire do_halt = exec & (op == mie_pkg::OP_HALT);
  wire do_wdt_clr = exec & (op == mie_pkg::OP_CLRWDT);
  wire core_mem_we = exec & to_mem;

  // A bus write into data memory waits while the core writes memory, so neither write is lost.
  wire bus_clash = bus_dmem & avs_write_in & core_mem_we;
  wire bus_take = bus_req & ~ack_q & ~bus_clash;
  wire bus_dmem_we = bus_take & bus_wr_lo & bus_dmem;
  wire bus_work_we = bus_take & bus_wr_lo & hit_work;

  // Adder shared by the addition forms.
  wire add_lit = op == mie_pkg::OP_ADDI;
  wire [7:0] addend = add_lit ? lit : mval;
  wire carry_in = ((op == mie_pkg::OP_ADC) | (op == mie_pkg::OP_ADD_WITH_CARRY_TO_MEMORY)) & borrow_out_bit;
  wire [4:0] low_sum = {1'b0, work_register[3:0]} + {1'b0, addend[3:0]} + {4'h0, carry_in};
  wire [8:0] sum9 = {1'b0, work_register} + {1'b0, addend} + {8'h00, carry_in};
  wire add_wrap = (work_register[7] == addend[7]) & (sum9[7] != work_register[7]);

  // Decimal adjust decisions look at the original nibbles and flags.
  wire adj_lo = (work_register[3:0] > mie_pkg::BCD_DIGIT_MAX) | nibble_carry_flag;
  wire adj_hi = (work_register[7:4] > mie_pkg::BCD_DIGIT_MAX) | borrow_out_bit;
  wire [7:0] daa_adj = {adj_hi ? mie_pkg::BCD_NIBBLE_ADJ : 4'h0, adj_lo ? mie_pkg::BCD_NIBBLE_ADJ : 4'h0};
  wire [8:0] daa9 = {1'b0, work_register} + {1'b0, daa_adj};

  // Watchdog.
  wire wdt_tick = wdt_pre == PRE_W'(WDT_PRESCALE - 1);
  wire wdt_expire = wdt_tick & (&watchdog_timer);
  wire wdt_clear = do_halt | do_wdt_clr;
  wire wake = bus_wake | wdt_expire | irq_sync;

  // Read data selection.
  wire [31:0] status_word = {23'h000000, state == mie_pkg::ST_SLEEP_ST, global_irq_gate, sleep_entered_flag,
    watchdog_expired_flag, signed_ovf_flag, signed_wrap_flag, nibble_carry_flag, borrow_out_bit, result_null_flag};
  wire [31:0] rd_word = bus_dmem ? {24'h000000, dmem[bus_idx]} :
    hit_ctrl ? {31'h00000000, state != mie_pkg::ST_SLEEP_ST} :
    hit_status ? status_word :
    hit_work ? {24'h000000, work_register} :
    hit_pc ? {21'h000000, pc} :
    hit_wdt ? {24'h000000, watchdog_timer} : 32'h00000000;

  assign avs_waitrequest_out = bus_req & ~ack_q;
  assign prog_addr_out = pc;
  assign sys_clk_en_out = state != mie_pkg::ST_SLEEP_ST;

  mie_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(mie_pkg::PC_W)
  ) u_stack (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .clear_in(bus_restart),
    .push_in(irq_take | (exec & (op == mie_pkg::OP_CALL))),
    .pop_in(exec & is_return),
    .push_data_in(irq_take ? pc : pc_inc),
    .top_out(stack_top)
  );

  // Result and destination of the data instructions.
  always_comb begin
    res = mval;
    to_acc = 1'b0;
    to_mem = 1'b0;
    set_arith = 1'b0;
    set_z = 1'b0;
    set_daa = 1'b0;
    case (op)
      mie_pkg::OP_ADC, mie_pkg::OP_ADD, mie_pkg::OP_ADDI: begin
        res = sum9[7:0];
        to_acc = 1'b1;
        set_arith = 1'b1;
      end
      mie_pkg::OP_ADD_WITH_CARRY_TO_MEMORY, mie_pkg::OP_SUM_TO_MEMORY: begin
        res = sum9[7:0];
        to_mem = 1'b1;
        set_arith = 1'b1;
      end
      mie_pkg::OP_AND, mie_pkg::OP_CONJUNCTION_TO_MEMORY: begin
        res = work_register & mval;
        to_acc = op == mie_pkg::OP_AND;
        to_mem = op == mie_pkg::OP_CONJUNCTION_TO_MEMORY;
        set_z = 1'b1;
      end
      mie_pkg::OP_ANDI: begin
        res = work_register & lit;
        to_acc = 1'b1;
        set_z = 1'b1;
      end
      mie_pkg::OP_OR, mie_pkg::OP_ORM: begin
        res = work_register | mval;
        to_acc = op == mie_pkg::OP_OR;
        to_mem = op == mie_pkg::OP_ORM;
        set_z = 1'b1;
      end
      mie_pkg::OP_ORI: begin
        res = work_register | lit;
        to_acc = 1'b1;
        set_z = 1'b1;
      end
      mie_pkg::OP_CLR: begin
        res = 8'h00;
        to_mem = 1'b1;
      end
      mie_pkg::OP_CLRB: begin
        res = mval & ~(8'h01 << bidx);
        to_mem = 1'b1;
      end
      mie_pkg::OP_CPL, mie_pkg::OP_INVERT_TO_WORK: begin
        res = ~mval;
        to_acc = op == mie_pkg::OP_INVERT_TO_WORK;
        to_mem = op == mie_pkg::OP_CPL;
        set_z = 1'b1;
      end
      mie_pkg::OP_DAA: begin
        res = daa9[7:0];
        to_mem = 1'b1;
        set_daa = 1'b1;
      end
      mie_pkg::OP_DEC, mie_pkg::OP_STEP_DOWN_TO_WORK: begin
        res = mval - 8'h01;
        to_acc = op == mie_pkg::OP_STEP_DOWN_TO_WORK;
        to_mem = op == mie_pkg::OP_DEC;
        set_z = 1'b1;
      end
      mie_pkg::OP_INC, mie_pkg::OP_STEP_UP_TO_WORK: begin
        res = mval + 8'h01;
        to_acc = op == mie_pkg::OP_STEP_UP_TO_WORK;
        to_mem = op == mie_pkg::OP_INC;
        set_z = 1'b1;
      end
      mie_pkg::OP_MOVAM: begin
        res = mval;
        to_acc = 1'b1;
      end
      mie_pkg::OP_MOVAI, mie_pkg::OP_RETA: begin
        res = lit;
        to_acc = 1'b1;
      end
      mie_pkg::OP_MOVMA: begin
        res = work_register;
        to_mem = 1'b1;
      end
      mie_pkg::OP_RL: begin
        res = {mval[6:0], mval[7]};
        to_mem = 1'b1;
      end
      default: begin
        res = mval;
      end
    endcase
  end

  // Sequencing: branches and interrupt entry spend one dummy cycle, everything else one cycle.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= mie_pkg::ST_SLEEP_ST;
      pc <= mie_pkg::PC_RESET;
    end else if (bus_restart) begin
      state <= mie_pkg::ST_RUN;
      pc <= mie_pkg::PC_RESET;
    end else begin
      case (state)
        mie_pkg::ST_RUN: begin
          if (irq_take) begin
            pc <= mie_pkg::IRQ_VECTOR;
            state <= mie_pkg::ST_DUMMY;
          end else if (is_branch) begin
            pc <= target;
            state <= mie_pkg::ST_DUMMY;
          end else if (is_return) begin
            pc <= stack_top;
          end else if (op == mie_pkg::OP_HALT) begin
            pc <= pc_inc;
            state <= mie_pkg::ST_SLEEP_ST;
          end else begin
            pc <= pc_inc;
          end
        end
        mie_pkg::ST_DUMMY: begin
          state <= mie_pkg::ST_RUN;
        end
        mie_pkg::ST_SLEEP_ST: begin
          if (wake) begin
            state <= mie_pkg::ST_RUN;
          end
        end
        default: begin
          state <= mie_pkg::ST_SLEEP_ST;
        end
      endcase
    end
  end

  // Work register and arithmetic flags.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      work_register <= 8'h00;
      result_null_flag <= 1'b0;
      borrow_out_bit <= 1'b0;
      nibble_carry_flag <= 1'b0;
      signed_wrap_flag <= 1'b0;
      signed_ovf_flag <= 1'b0;
    end else begin
      if (exec & to_acc) begin
        work_register <= res;
      end else if (bus_work_we) begin
        work_register <= avs_writedata_in[7:0];
      end
      if (exec & set_arith) begin
        borrow_out_bit <= sum9[8];
        nibble_carry_flag <= low_sum[4];
        signed_wrap_flag <= add_wrap;
        signed_ovf_flag <= add_wrap ^ sum9[7];
        result_null_flag <= sum9[7:0] == 8'h00;
      end
      if (exec & set_z) begin
        result_null_flag <= res == 8'h00;
      end
      if (exec & set_daa) begin
        borrow_out_bit <= borrow_out_bit | daa9[8];
      end
    end
  end

  // Interrupt gate, closed on entry and reopened by the interrupt return.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || bus_restart) begin
      global_irq_gate <= 1'b0;
    end else if (irq_take) begin
      global_irq_gate <= 1'b0;
    end else if (exec & (op == mie_pkg::OP_LEAVE_INTERRUPT_HANDLER)) begin
      global_irq_gate <= 1'b1;
    end
  end

  // Data memory has no reset; its contents survive halt and restart.
  always_ff @(posedge clk_in) begin
    if (core_mem_we) begin
      dmem[maddr] <= res;
    end else if (bus_dmem_we) begin
      dmem[bus_idx] <= avs_writedata_in[7:0];
    end
  end

  // Watchdog keeps running in sleep so that it can wake the core.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || wdt_clear) begin
      wdt_pre <= '0;
      watchdog_timer <= '0;
    end else begin
      wdt_pre <= wdt_tick ? '0 : wdt_pre + 1'b1;
      if (wdt_tick) begin
        watchdog_timer <= watchdog_timer + 1'b1;
      end
    end
  end

  // An expiry in the same cycle as a clear still sets the flag.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      watchdog_expired_flag <= 1'b0;
      sleep_entered_flag <= 1'b0;
    end else begin
      if (wdt_expire) begin
        watchdog_expired_flag <= 1'b1;
      end else if (wdt_clear) begin
        watchdog_expired_flag <= 1'b0;
      end
      if (do_halt) begin
        sleep_entered_flag <= 1'b1;
      end else if (do_wdt_clr) begin
        sleep_entered_flag <= 1'b0;
      end
    end
  end

  // Interrupt pin synchroniser.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_meta <= 1'b0;
      irq_sync <= 1'b0;
    end else begin
      irq_meta <= irq_in;
      irq_sync <= irq_meta;
    end
  end

  // Bus answer one cycle after the request is taken.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ack_q <= 1'b0;
      avs_readdata_out <= 32'h00000000;
    end else begin
      ack_q <= bus_take;
      if (bus_take & avs_read_in) begin
        avs_readdata_out <= rd_word;
      end
    end
  end

endmodule
`default_nettype wire

// File: tb/mie_prog_rom.sv
`timescale 1ns/1ps
`default_nettype none
module mie_prog_rom (
  // Fetch address.
  input wire logic [mie_pkg::PC_W-1:0] addr_in,
  // Instruction word, same cycle.
  output logic [mie_pkg::INSTR_W-1:0] data_out
);
  // Unused words hold the no-operation code, so a stray fetch never feeds unknowns to the core.
  logic [mie_pkg::INSTR_W-1:0] words [0:(1<<mie_pkg::PC_W)-1];
  initial begin
    foreach (words[k]) begin
      words[k] = 16'h0000;
    end
  end
  assign data_out = words[addr_in];
endmodule
`default_nettype wire

// File: tb/mie_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mie_core_monitor (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Watched ports.
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic [mie_pkg::PC_W-1:0] prog_addr_out,
  input wire logic [mie_pkg::INSTR_W-1:0] prog_data_in,
  input wire logic irq_in,
  input wire logic sys_clk_en_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // The slot after a branch fetches a word that is thrown away, so it must not count as executed.
  logic dummy_q;
  wire logic [4:0] opc = prog_data_in[15:11];
  wire logic exec = sys_clk_en_out && !dummy_q;
  wire logic is_br = opc inside {mie_pkg::OP_CALL, mie_pkg::OP_JMP};
  wire logic is_flow = is_br || opc inside {mie_pkg::OP_HALT, mie_pkg::OP_RET, mie_pkg::OP_RETA, mie_pkg::OP_LEAVE_INTERRUPT_HANDLER};
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      dummy_q <= 1'b0;
    end else begin
      dummy_q <= exec && is_br;
    end
  end
  sequence land_twice;
    prog_addr_out == $past(prog_data_in[10:0]) ##1 prog_addr_out == $past(prog_data_in[10:0], 2);
  endsequence
  a_call_lands: assert property (exec && opc == mie_pkg::OP_CALL |=> land_twice)
    else $error("call target not held for two cycles");
  a_jump_lands: assert property (exec && opc == mie_pkg::OP_JMP |=> land_twice)
    else $error("jump target not held for two cycles");
  // Interrupt entry may replace the next address, so the check waits for a quiet request line.
  a_single_step: assert property (exec && !is_flow && !irq_in && !$past(irq_in) && !$past(irq_in, 2)
    && !$past(irq_in, 3) |=> prog_addr_out == $past(prog_addr_out) + 1'b1)
    else $error("plain instruction did not advance by one");
  a_halt_stops: assert property (exec && opc == mie_pkg::OP_HALT |=>
    !sys_clk_en_out && prog_addr_out == $past(prog_addr_out) + 1'b1)
    else $error("halt did not stop the clock");
  a_halt_keeps: assert property (!sys_clk_en_out && !$past(sys_clk_en_out) |-> $stable(prog_addr_out))
    else $error("program counter moved while halted");
  a_bus_first_wait: assert property ($rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out)
    else $error("request answered without a wait cycle");
  a_bus_answers: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |-> ##[1:16] !avs_waitrequest_out)
    else $error("bus request never answered");
  a_bus_idle: assert property (!avs_read_in && !avs_write_in |-> !avs_waitrequest_out)
    else $error("wait raised with no request");
  a_read_stands: assert property (!$past(avs_read_in) |-> $stable(avs_readdata_out))
    else $error("read data changed without a read");
endmodule
bind mie_core mie_core_monitor mon_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .prog_addr_out(prog_addr_out), .prog_data_in(prog_data_in), .irq_in(irq_in), .sys_clk_en_out(sys_clk_en_out));
`default_nettype wire

// File: tb/tb_mie_core.sv
`timescale 1ns/1ps
`default_nettype none
module tb_mie_core;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [10:0] avs_address_in = 11'h000;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic [10:0] prog_addr_out;
  logic [15:0] prog_data_in;
  logic irq_in = 1'b0;
  logic sys_clk_en_out;
  int miscompares = 0;
  int n_checks = 0;
  always #4 clk_in = ~clk_in;
  mie_core #(.WDT_PRESCALE(4)) mie_core_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .prog_addr_out(prog_addr_out), .prog_data_in(prog_data_in),
    .irq_in(irq_in), .sys_clk_en_out(sys_clk_en_out));
  mie_prog_rom mie_prog_rom_i (.addr_in(prog_addr_out), .data_out(prog_data_in));
  task automatic results();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [10:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    avs_read_in <= !wr;
    avs_write_in <= wr;
    // Waitrequest and read data are taken as they stood at the rising edge, before that edge updates them.
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    if (n == 50) miscompares++;
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic wr(input logic [10:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask
  task automatic chk_reg(input logic [10:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    n_checks++;
    if (q !== e) begin
      miscompares++;
      $display("unexpected reg %h expected %h seen %h", a, e, q);
    end
  endtask
  function automatic logic [10:0] dm(input int i);
    return 11'h400 + 11'(4 * i);
  endfunction
  function automatic logic [15:0] ins(input mie_pkg::mie_op_t op, input logic [10:0] arg);
    return {op, arg};
  endfunction
  task automatic load(input logic [15:0] p[$]);
    foreach (p[k]) mie_prog_rom_i.words[k] = p[k];
  endtask
  // Restart from address zero and wait for the program's final halt.
  task automatic run();
    int n;
    n = 0;
    wr(mie_pkg::REG_CTRL, 32'h2);
    while (sys_clk_en_out !== 1'b0 && n < 200) begin
      @(negedge clk_in);
      n++;
    end
    if (n == 200) miscompares++;
  endtask
  task automatic t_regs();
    chk_reg(mie_pkg::REG_STATUS, 32'h100);
    wr(mie_pkg::REG_STATUS, 32'hFF);
    chk_reg(mie_pkg::REG_STATUS, 32'h100);
    chk_reg(11'h020, 32'h0);
    wr(mie_pkg::REG_WORK, 32'h5C);
    wr(mie_pkg::REG_WORK, 32'hA1, 4'h0);
    chk_reg(mie_pkg::REG_WORK, 32'h5C);
    chk_reg(mie_pkg::REG_CTRL, 32'h0);
  endtask
  task automatic t_arith();
    wr(dm(1), 32'h38);
    load('{ins(mie_pkg::OP_MOVAI, 11'h045), ins(mie_pkg::OP_ADD, 11'h001), ins(mie_pkg::OP_DAA, 11'h002),
      ins(mie_pkg::OP_ADDI, 11'h090), ins(mie_pkg::OP_ADC, 11'h001), ins(mie_pkg::OP_SUM_TO_MEMORY, 11'h001),
      ins(mie_pkg::OP_ADDI, 11'h03A), ins(mie_pkg::OP_DAA, 11'h003), ins(mie_pkg::OP_HALT, 11'h000)});
    run();
    chk_reg(dm(2), 32'h83);
    chk_reg(dm(1), 32'h7E);
    chk_reg(mie_pkg::REG_WORK, 32'h80);
    chk_reg(dm(3), 32'h86);
    chk_reg(mie_pkg::REG_STATUS, 32'h14C);
    chk_reg(mie_pkg::REG_PC, 32'h9);
  endtask
  task automatic t_logic();
    wr(dm(3), 32'hF0);
    wr(dm(5), 32'h01);
    load('{ins(mie_pkg::OP_MOVAI, 11'h00F), ins(mie_pkg::OP_AND, 11'h003), ins(mie_pkg::OP_ORM, 11'h003),
      ins(mie_pkg::OP_CPL, 11'h003), ins(mie_pkg::OP_RL, 11'h003), ins(mie_pkg::OP_STEP_UP_TO_WORK, 11'h003),
      ins(mie_pkg::OP_DEC, 11'h003), ins(mie_pkg::OP_CLRB, 11'h203), ins(mie_pkg::OP_MOVMA, 11'h004),
      ins(mie_pkg::OP_STEP_DOWN_TO_WORK, 11'h005), ins(mie_pkg::OP_ORI, 11'h024), ins(mie_pkg::OP_CONJUNCTION_TO_MEMORY, 11'h004),
      ins(mie_pkg::OP_INVERT_TO_WORK, 11'h004), ins(mie_pkg::OP_INC, 11'h005), ins(mie_pkg::OP_MOVAM, 11'h004),
      ins(mie_pkg::OP_HALT, 11'h000)});
    run();
    chk_reg(dm(3), 32'h19);
    chk_reg(dm(4), 32'h04);
    chk_reg(dm(5), 32'h02);
    chk_reg(mie_pkg::REG_WORK, 32'h04);
    chk_reg(mie_pkg::REG_STATUS, 32'h14C);
  endtask
  task automatic t_flow();
    wr(dm(6), 32'hAA);
    load('{ins(mie_pkg::OP_JMP, 11'h003), ins(mie_pkg::OP_MOVAI, 11'h0EE), ins(mie_pkg::OP_HALT, 11'h000),
      ins(mie_pkg::OP_CALL, 11'h010), ins(mie_pkg::OP_CLR, 11'h006), ins(mie_pkg::OP_HALT, 11'h000)});
    mie_prog_rom_i.words[16] = ins(mie_pkg::OP_NOP, 11'h000);
    mie_prog_rom_i.words[17] = ins(mie_pkg::OP_RETA, 11'h05A);
    run();
    chk_reg(mie_pkg::REG_WORK, 32'h5A);
    chk_reg(dm(6), 32'h00);
    chk_reg(mie_pkg::REG_PC, 32'h6);
  endtask
  task automatic t_irq();
    load('{ins(mie_pkg::OP_CALL, 11'h020), ins(mie_pkg::OP_MOVAI, 11'h033), ins(mie_pkg::OP_HALT, 11'h000),
      ins(mie_pkg::OP_NOP, 11'h000), ins(mie_pkg::OP_MOVAI, 11'h077), ins(mie_pkg::OP_JMP, 11'h005)});
    mie_prog_rom_i.words[32] = ins(mie_pkg::OP_NOP, 11'h000);
    mie_prog_rom_i.words[33] = ins(mie_pkg::OP_NOP, 11'h000);
    mie_prog_rom_i.words[34] = ins(mie_pkg::OP_LEAVE_INTERRUPT_HANDLER, 11'h000);
    wr(mie_pkg::REG_CTRL, 32'h2);
    @(posedge clk_in);
    irq_in <= 1'b1;
    repeat (30) @(posedge clk_in);
    chk_reg(mie_pkg::REG_WORK, 32'h77);
    chk_reg(mie_pkg::REG_PC, 32'h5);
    irq_in <= 1'b0;
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    results();
  end
  initial begin
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_arith();
    t_logic();
    t_flow();
    t_irq();
    results();
  end
endmodule
`default_nettype wire
